// ---- ctm_map.svh ----
// register offsets, field positions and reset values of the compact timer
`ifndef CTM_MAP_SVH
`define CTM_MAP_SVH
`define CTM_OFF_ROUTE   12'h000
`define CTM_OFF_CTRL_A  12'h004
`define CTM_OFF_CTRL_B  12'h008
`define CTM_OFF_CNT_LO  12'h00C
`define CTM_OFF_CNT_HI  12'h010
`define CTM_OFF_MAT_LO  12'h014
`define CTM_OFF_MAT_HI  12'h018
`define CTM_RST_BYTE    8'h00
`define CTM_ROUTE_BITS  4
`define CTM_A_PAUSE     7
`define CTM_A_CLK_HI    6
`define CTM_A_CLK_LO    4
`define CTM_A_ON        3
`define CTM_A_PER_HI    2
`define CTM_B_MODE_HI   7
`define CTM_B_MODE_LO   6
`define CTM_B_IO_HI     5
`define CTM_B_IO_LO     4
`define CTM_B_INIT      3
`define CTM_B_POL       2
`define CTM_B_CLR_SEL   0
`define CTM_DIV_SYS     4
`define CTM_DIV_H16     16
`define CTM_DIV_H64     64
`endif

// ---- ctm_pkg.sv ----
// types shared by the compact timer
package ctm_pkg;
  typedef enum logic [2:0] {
    CTM_CK_SYS4 = 3'h0, CTM_CK_SYS = 3'h1, CTM_CK_H16 = 3'h2, CTM_CK_H64 = 3'h3,
    CTM_CK_SUB = 3'h4, CTM_CK_RSVD = 3'h5, CTM_CK_EXT_RISE = 3'h6, CTM_CK_EXT_FALL = 3'h7
  } ctm_clk_sel_t;
  typedef enum logic [1:0] {
    CTM_MODE_CMP = 2'h0, CTM_MODE_UNDEF = 2'h1, CTM_MODE_PWM = 2'h2, CTM_MODE_TMR = 2'h3
  } ctm_mode_t;
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } ctm_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ctm_apb_rsp_t;
  typedef struct packed {
    logic [3:0] route;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [9:0] count;
    logic [9:0] match;
    logic [7:0] hold;
    logic [5:0] presc;
    logic [1:0] ext_sync;
    logic       ext_prev;
    logic       hsub_prev;
    logic       on_prev;
    logic       out_lvl;
    logic       per_flag;
    logic       full_flag;
    logic       irq;
    logic [3:0] first_oe;
    logic [3:0] second_oe;
    logic [3:0] first_out;
    logic [3:0] second_out;
    ctm_apb_rsp_t rsp;
  } ctm_state_t;
endpackage

// ---- ctm_timer.sv ----
// compact 10-bit timer with apb register access and routed output pins
`timescale 1ns/1ns
`include "ctm_map.svh"
module ctm_timer
  import ctm_pkg::*;
#(
  parameter int TIMERS = `CTM_ROUTE_BITS
) (
  // apb clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb request
  input  wire ctm_apb_req_t apb_req,
  // apb response
  output ctm_apb_rsp_t      apb_rsp,
  // clock sources from the system and from the pin
  input  wire logic         high_clk_tick,
  input  wire logic         sub_clk_in,
  input  wire logic         external_count_input,
  // timer event towards the interrupt controller
  output logic              timer_irq,
  output logic              period_match_flag,
  output logic              full_match_flag,
  // output pins, per timer: first and second pin, enables active low
  output logic [3:0]        timer_out_first_pin,
  output logic [3:0]        timer_out_first_pin_oe_n,
  output logic [3:0]        timer_out_second_pin,
  output logic [3:0]        timer_out_second_pin_oe_n
);

  initial begin
    if (TIMERS != `CTM_ROUTE_BITS) begin
      $error("ctm_timer: TIMERS must match the route register width");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte lane of a 10-bit value: low eight or the top two padded with zero
  function automatic logic [31:0] ctm_hi_word(input logic [9:0] v);
    ctm_hi_word = {30'h00000000, v[9:8]};
  endfunction

  function automatic logic [31:0] ctm_byte_word(input logic [7:0] v);
    ctm_byte_word = {24'h000000, v};
  endfunction

  ctm_state_t s_r;
  ctm_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    logic         acc;
    logic         wr;
    logic         rd;
    logic         on_bit;
    logic         pause_bit;
    logic         tick;
    logic         ext_rise;
    logic         ext_fall;
    logic         sub_rise;
    logic         per_hit;
    logic         full_hit;
    logic         ovf;
    logic         clr;
    logic [2:0]   per_val;
    ctm_clk_sel_t cks;
    ctm_mode_t    mode;
    logic [1:0]   io;
    logic         lvl;
    s_nxt     = s_r;
    tick      = 1'b0;
    acc       = apb_req.psel && apb_req.penable;
    wr        = acc && apb_req.pwrite;
    rd        = acc && !apb_req.pwrite;
    on_bit    = s_r.ctrl_a[`CTM_A_ON];
    pause_bit = s_r.ctrl_a[`CTM_A_PAUSE];
    per_val   = s_r.ctrl_a[`CTM_A_PER_HI:0];
    cks       = ctm_clk_sel_t'(s_r.ctrl_a[`CTM_A_CLK_HI:`CTM_A_CLK_LO]);
    mode      = ctm_mode_t'(s_r.ctrl_b[`CTM_B_MODE_HI:`CTM_B_MODE_LO]);
    io        = s_r.ctrl_b[`CTM_B_IO_HI:`CTM_B_IO_LO];

    // pin input passes two flops; edges seen only on the second one
    s_nxt.ext_sync = {s_r.ext_sync[0], external_count_input};
    s_nxt.ext_prev = s_r.ext_sync[1];
    s_nxt.hsub_prev = sub_clk_in;
    ext_rise = s_r.ext_sync[1] && !s_r.ext_prev;
    ext_fall = !s_r.ext_sync[1] && s_r.ext_prev;
    sub_rise = sub_clk_in && !s_r.hsub_prev;

    // prescaler runs only while on, keeping power down when off
    s_nxt.presc = on_bit ? s_r.presc + 6'h01 : 6'h00;
    case (cks)
      CTM_CK_SYS4:     tick = s_r.presc[1:0] == 2'(`CTM_DIV_SYS - 1);
      CTM_CK_SYS:      tick = 1'b1;
      CTM_CK_H16:      tick = high_clk_tick && (s_r.presc[3:0] == 4'(`CTM_DIV_H16 - 1));
      CTM_CK_H64:      tick = high_clk_tick && (s_r.presc == 6'(`CTM_DIV_H64 - 1));
      CTM_CK_SUB:      tick = sub_rise;
      CTM_CK_EXT_RISE: tick = ext_rise;
      CTM_CK_EXT_FALL: tick = ext_fall;
      default:         tick = 1'b0;
    endcase
    // high/16 and high/64 count tick strobes, so the prescaler only moves on them
    if ((cks == CTM_CK_H16) || (cks == CTM_CK_H64)) begin
      s_nxt.presc = (on_bit && high_clk_tick) ? s_r.presc + 6'h01 : (on_bit ? s_r.presc : 6'h00);
    end

    // comparators and clearing
    per_hit  = (per_val != 3'h0) && (s_r.count[9:7] == per_val) && (s_r.count[6:0] == 7'h00);
    full_hit = s_r.count == s_r.match;
    ovf      = tick && (s_r.count == 10'h3FF);
    clr      = s_r.ctrl_b[`CTM_B_CLR_SEL] ? full_hit : (per_hit || ovf);
    s_nxt.per_flag  = on_bit && (per_hit || ovf);
    s_nxt.full_flag = on_bit && full_hit;
    s_nxt.irq       = on_bit && tick && clr;

    if (on_bit && !s_r.on_prev) begin
      s_nxt.count = 10'h000;
    end else if (on_bit && !pause_bit && tick) begin
      s_nxt.count = clr ? 10'h000 : s_r.count + 10'h001;
    end
    s_nxt.on_prev = on_bit;

    // compare-match output level
    lvl = s_r.out_lvl;
    if (on_bit && !s_r.on_prev) begin
      lvl = s_r.ctrl_b[`CTM_B_INIT];
    end else if (!on_bit) begin
      lvl = s_r.ctrl_b[`CTM_B_INIT];
    end else if ((mode == CTM_MODE_CMP) && full_hit && tick) begin
      case (io)
        2'h1:    lvl = 1'b0;
        2'h2:    lvl = 1'b1;
        2'h3:    lvl = !s_r.out_lvl;
        default: lvl = s_r.out_lvl;
      endcase
    end
    s_nxt.out_lvl = lvl;

    // pin routing: bit 0 is this timer, other route bits are only stored and read back
    s_nxt.first_oe   = 4'hF;
    s_nxt.second_oe  = 4'hF;
    s_nxt.first_out  = 4'h0;
    s_nxt.second_out = 4'h0;
    if (on_bit && (mode != CTM_MODE_TMR)) begin
      if (s_r.route[0]) begin
        s_nxt.second_oe[0]  = 1'b0;
        s_nxt.second_out[0] = lvl ^ s_r.ctrl_b[`CTM_B_POL];
      end else begin
        s_nxt.first_oe[0]  = 1'b0;
        s_nxt.first_out[0] = lvl ^ s_r.ctrl_b[`CTM_B_POL];
      end
    end

    // apb slave: zero wait state, unmapped reads zero and error
    s_nxt.rsp.pready  = apb_req.psel && !apb_req.penable;
    s_nxt.rsp.pslverr = 1'b0;
    s_nxt.rsp.prdata  = 32'h00000000;
    if (apb_req.psel && !apb_req.penable) begin
      if (apb_req.paddr == `CTM_OFF_ROUTE) begin
        s_nxt.rsp.prdata = {28'h0000000, s_r.route};
      end else if (apb_req.paddr == `CTM_OFF_CTRL_A) begin
        s_nxt.rsp.prdata = ctm_byte_word(s_r.ctrl_a);
      end else if (apb_req.paddr == `CTM_OFF_CTRL_B) begin
        s_nxt.rsp.prdata = ctm_byte_word(s_r.ctrl_b);
      end else if ((apb_req.paddr == `CTM_OFF_CNT_LO) || (apb_req.paddr == `CTM_OFF_MAT_LO)) begin
        s_nxt.rsp.prdata = ctm_byte_word(s_r.hold);
      end else if (apb_req.paddr == `CTM_OFF_CNT_HI) begin
        s_nxt.rsp.prdata = ctm_hi_word(s_r.count);
      end else if (apb_req.paddr == `CTM_OFF_MAT_HI) begin
        s_nxt.rsp.prdata = ctm_hi_word(s_r.match);
      end else begin
        s_nxt.rsp.pslverr = 1'b1;
      end
    end

    // register side effects at the access edge
    if (wr) begin
      if (apb_req.paddr == `CTM_OFF_ROUTE) begin
        s_nxt.route = apb_req.pwdata[3:0];
      end else if (apb_req.paddr == `CTM_OFF_CTRL_A) begin
        s_nxt.ctrl_a = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == `CTM_OFF_CTRL_B) begin
        s_nxt.ctrl_b = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == `CTM_OFF_MAT_LO) begin
        s_nxt.hold = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == `CTM_OFF_MAT_HI) begin
        s_nxt.match = {apb_req.pwdata[1:0], s_r.hold};
      end
    end else if (rd) begin
      // order matters: a low read after a high read sees the latched byte
      if (apb_req.paddr == `CTM_OFF_CNT_HI) begin
        s_nxt.hold = s_r.count[7:0];
      end else if (apb_req.paddr == `CTM_OFF_MAT_HI) begin
        s_nxt.hold = s_r.match[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r           <= '0;
      s_r.first_oe  <= 4'hF;
      s_r.second_oe <= 4'hF;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign apb_rsp                   = s_r.rsp;
  assign timer_irq                 = s_r.irq;
  assign period_match_flag         = s_r.per_flag;
  assign full_match_flag           = s_r.full_flag;
  assign timer_out_first_pin       = s_r.first_out;
  assign timer_out_first_pin_oe_n  = s_r.first_oe;
  assign timer_out_second_pin      = s_r.second_out;
  assign timer_out_second_pin_oe_n = s_r.second_oe;

endmodule

// ---- ctm_assertions.sv ----
// concurrent checks on the compact timer's bus and pin ports
`timescale 1ns/1ns
module ctm_checker
  import ctm_pkg::*;
(
  // clock and reset
  input wire logic         pclk,
  input wire logic         presetn,
  // register bus
  input wire ctm_apb_req_t apb_req,
  input wire ctm_apb_rsp_t apb_rsp,
  // pin enables, low while driving
  input wire logic [3:0]   timer_out_first_pin_oe_n,
  input wire logic [3:0]   timer_out_second_pin_oe_n
);
  logic       on_m, on_p, rt_m, wr, rdv, f0, s0;
  logic [1:0] md_m;
  assign wr  = apb_req.psel & apb_req.penable & apb_rsp.pready & apb_req.pwrite;
  assign rdv = apb_rsp.pready & ~apb_req.pwrite;
  assign f0  = timer_out_first_pin_oe_n[0];
  assign s0  = timer_out_second_pin_oe_n[0];
  ////////////////////////////////////////
  // mirror of the control bits the pin checks rest on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_m <= 1'b0;
      on_p <= 1'b0;
      rt_m <= 1'b0;
      md_m <= 2'h0;
    end else begin
      on_p <= on_m;
      if (wr && apb_req.paddr == 12'h004) on_m <= apb_req.pwdata[3];
      if (wr && apb_req.paddr == 12'h000) rt_m <= apb_req.pwdata[0];
      if (wr && apb_req.paddr == 12'h008) md_m <= apb_req.pwdata[7:6];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // pins lag a control write by one cycle, hence the stability terms
  a_ready_zero_wait: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("pready missing in first access cycle");
  a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  a_route_upper_zero: assert property (rdv && apb_req.paddr == 12'h000 |-> apb_rsp.prdata[31:4] == 28'h0)
    else $error("route upper bits not zero");
  a_high_byte_width: assert property (rdv && apb_req.paddr inside {12'h010, 12'h018} |-> !(|apb_rsp.prdata[31:2]))
    else $error("high byte wider than two bits");
  a_unmapped_error: assert property (apb_rsp.pready && apb_req.paddr > 12'h018 |-> apb_rsp.pslverr && !(|apb_rsp.prdata))
    else $error("unmapped access not refused");
  a_pins_exclusive: assert property (f0 || s0)
    else $error("both pins driven");
  a_off_released: assert property (!on_m && !on_p |-> f0 && s0)
    else $error("pin driven while off");
  a_route_select: assert property (on_m && on_p && md_m != 2'h3 && $stable(rt_m) && $stable(md_m) |-> f0 == rt_m && s0 == !rt_m)
    else $error("wrong pin selected");
endmodule

// ---- ctm_pin_src.sv ----
// clock sources and external count pin in front of the timer
`timescale 1ns/1ns
module ctm_pin_src (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // sources
  output logic      high_clk_tick,
  output logic      sub_clk_in,
  output logic      external_count_input
);
  logic [3:0] ph_r;
  // free phase; pin edges far apart so the two-flop delay never merges them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ph_r <= 4'h0;
    else ph_r <= ph_r + 4'h1;
  end
  assign high_clk_tick        = ph_r[0]; // strobe every second cycle
  assign sub_clk_in           = ph_r[2]; // rising every 8 cycles
  assign external_count_input = ph_r[3]; // one edge each way per 16 cycles
endmodule

// ---- ctm_tb.sv ----
// bench for the compact timer: registers, buffered bytes, clock sources, pins
`timescale 1ns/1ns
module testbench;
  import ctm_pkg::*;
  localparam int W = 512;
  logic         pclk, presetn, hck, sck, ext, irq, er;
  ctm_apb_req_t req;
  ctm_apb_rsp_t rsp;
  logic [3:0]   p1, p2;
  logic [31:0]  rd;
  logic [9:0]   c0, c1, m;
  int           n_fail, num_checks, n_irq, k0, seed;
  // clock and timer event count
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  always @(posedge pclk) n_irq <= n_irq + int'(irq);
  ctm_pin_src src (.pclk(pclk), .presetn(presetn), .high_clk_tick(hck), .sub_clk_in(sck),
    .external_count_input(ext));
  ctm_timer dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .high_clk_tick(hck),
    .sub_clk_in(sck), .external_count_input(ext), .timer_irq(irq), .period_match_flag(),
    .full_match_flag(), .timer_out_first_pin(p1), .timer_out_first_pin_oe_n(),
    .timer_out_second_pin(p2), .timer_out_second_pin_oe_n());
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready, with an idle cycle after
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 40);
    if (k >= 40) begin
      n_fail++;
      $display("[FAIL] %0t no pready on the register bus", $time);
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask
  // counter read, high byte first
  task automatic cnt(output logic [9:0] v);
    apb(1'b0, 12'h010, 0);
    v[9:8] = rd[1:0];
    apb(1'b0, 12'h00C, 0);
    v[7:0] = rd[7:0];
  endtask
  // counter must stay at or below its clear point; route bit moved meanwhile
  task automatic samp(input logic [9:0] lim);
    for (int i = 0; i < 16; i++) begin
      repeat ($random(seed) & 15) @(posedge pclk);
      apb(1'b1, 12'h000, $random(seed));
      cnt(c0);
      chk(c0 <= lim, 1);
    end
  endtask
  // counts over W cycles from the partner's source rates
  function automatic int exp_cnt(input int c);
    int dv[8] = '{4, 1, 32, 128, 8, 0, 16, 16};
    return dv[c] == 0 ? 0 : W / dv[c];
  endfunction
  task automatic stop_test;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #200000;
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test;
  end
  initial begin
    seed = 57203;
    presetn = 1'b0;
    req = '0;
    {n_fail, num_checks, n_irq} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 12; a += 4) begin
      apb(1'b0, a[11:0], 0);
      chk(rd, 0);
    end
    m = $random(seed);
    apb(1'b1, 12'h000, {24'h0, m[7:0]});
    apb(1'b0, 12'h000, 0);
    chk(rd, m[3:0]);
    apb(1'b0, 12'h100, 0);
    chk(er, 1);
    $display("test registers done");
    c0 = $random(seed);
    c1 = ~c0;
    apb(1'b1, 12'h014, 32'hA5);
    apb(1'b0, 12'h018, 0);
    apb(1'b0, 12'h014, 0);
    chk(rd, 0);
    apb(1'b1, 12'h014, c0[7:0]);
    apb(1'b1, 12'h018, c0[9:8]);
    apb(1'b1, 12'h014, c1[7:0]);
    apb(1'b0, 12'h014, 0);
    chk(rd, c1[7:0]);
    apb(1'b0, 12'h018, 0);
    chk(rd, c0[9:8]);
    apb(1'b0, 12'h014, 0);
    chk(rd, c0[7:0]);
    $display("test buffer done");
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h004, 0);
      apb(1'b1, 12'h004, {25'h0, c[2:0], 4'h8});
      repeat (W) @(posedge pclk);
      apb(1'b1, 12'h004, {24'h0, 1'b1, c[2:0], 4'h8});
      cnt(c0);
      k0 = exp_cnt(c);
      chk((c0 > k0 ? c0 - k0 : k0 - c0) <= (k0 + 7) / 8 + (k0 != 0), 1);
    end
    $display("test clocks done");
    apb(1'b1, 12'h004, 32'h98);
    cnt(c0);
    repeat (30) @(posedge pclk);
    cnt(c1);
    chk(c1, c0);
    apb(1'b1, 12'h004, 32'h18);
    repeat (20) @(posedge pclk);
    cnt(c1);
    chk(c1 >= c0 + 20 && c1 <= c0 + 40, 1);
    apb(1'b1, 12'h004, 32'h10);
    cnt(c0);
    repeat (30) @(posedge pclk);
    cnt(c1);
    chk(c1 == c0 && c0 > 20, 1);
    apb(1'b1, 12'h004, 32'h18);
    cnt(c0);
    chk(c0 < 12, 1);
    $display("test pause done");
    m = 10'd20 + 10'($random(seed) & 63);
    apb(1'b1, 12'h014, {24'h0, m[7:0]});
    apb(1'b1, 12'h018, {30'h0, m[9:8]});
    apb(1'b1, 12'h008, 32'h09);
    apb(1'b1, 12'h004, 32'h10);
    k0 = n_irq;
    apb(1'b1, 12'h004, 32'h18);
    apb(1'b0, 12'h000, 0);
    chk(rd[0] ? p2[0] : p1[0], 1);
    samp(m);
    chk(n_irq > k0, 1);
    apb(1'b1, 12'h008, 32'h00);
    apb(1'b1, 12'h004, 32'h10);
    k0 = n_irq;
    apb(1'b1, 12'h004, 32'h19);
    samp(10'd128);
    chk(n_irq > k0, 1);
    $display("test clearing done");
    stop_test;
  end
endmodule
bind ctm_timer ctm_checker u_chk (.pclk, .presetn, .apb_req, .apb_rsp, .timer_out_first_pin_oe_n,
  .timer_out_second_pin_oe_n);
